// file: testbench/tb_tmr_timer16.sv
`timescale 1ns/1ps
module tb_tmr_timer16;
  import tmr_pkg::*;
  logic      clock;
  logic      nrst;
  tmr_bus_s  bus_req;
  logic [7:0] bus_rdata;
  logic      timer_tick;
  logic      capture_pin;
  logic      comparator_output;
  logic      comparator_capture_select;
  logic      capture_irq_ack;
  logic      overflow_irq_ack;
  logic      capture_irq;
  logic      overflow_irq;
  logic      wave_out_a;
  logic      wave_out_b;
  logic      wave_ovr_a;
  logic      wave_ovr_b;
  int        mismatches;
  int        check_count;
  int        cycles;
  int        n0;
  int        n1;
  logic      ea;
  logic      eb;
  logic [1:0] act;

  tmr_timer16 tmr_timer16_i (.clock(clock), .nrst(nrst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .timer_tick(timer_tick), .capture_pin(capture_pin),
    .comparator_output(comparator_output),
    .comparator_capture_select(comparator_capture_select),
    .capture_irq_ack(capture_irq_ack), .overflow_irq_ack(overflow_irq_ack),
    .capture_irq(capture_irq), .overflow_irq(overflow_irq), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .wave_ovr_a(wave_ovr_a), .wave_ovr_b(wave_ovr_b));
  tmr_cpu_model tmr_cpu_model_i (.clock(clock), .bus_req(bus_req), .bus_rdata(bus_rdata));

  always #5 clock = ~clock;

  task automatic results;
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      results();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    tmr_cpu_model_i.access(a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    tmr_cpu_model_i.access(a, 8'h00, 1'b0, q);
    check(16'(q), 16'(e));
  endtask
  task automatic w16(input logic [5:0] a, input logic [15:0] v);
    tmr_cpu_model_i.write16(a, v);
  endtask
  task automatic r16(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] q;
    tmr_cpu_model_i.read16(a, q);
    check(q, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic tick(input int n);
    timer_tick = 1'b1;
    repeat (n) @(posedge clock);
    #1 timer_tick = 1'b0;
    idle(2);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clock);
    #1 s = 1'b0;
  endtask
  task automatic edge_wait(output int n);
    n = 0;
    while (capture_irq !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1 n++;
    end
    check(16'(capture_irq), 16'h0001);
  endtask
  function automatic logic nxt(input logic v, input logic [1:0] a);
    return (a == ACT_TOGGLE) ? ~v : (a == ACT_LOW) ? 1'b0 : (a == ACT_HIGH) ? 1'b1 : v;
  endfunction

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    timer_tick = 1'b0;
    capture_pin = 1'b0;
    comparator_output = 1'b0;
    comparator_capture_select = 1'b0;
    capture_irq_ack = 1'b0;
    overflow_irq_ack = 1'b0;
    repeat (4) @(posedge clock);
    #1 nrst = 1'b1;
    rd(OFS_CTRL1, CTRL1_RST);
    wr(OFS_CTRL1, 8'hff);
    rd(OFS_CTRL1, 8'hf3);
    rd(6'h30, 8'h00);
    wr(OFS_CTRL1, 8'h00);
    // Byte access through the shared high byte
    w16(OFS_CMPA_LO, 16'h1234);
    w16(OFS_CMPB_LO, 16'h5678);
    rd(OFS_CMPA_HI, 8'h12);
    wr(OFS_CMPA_HI, 8'hab);
    wr(OFS_CMPB_LO, 8'h9a);
    r16(OFS_CMPB_LO, 16'hab9a);
    r16(OFS_CMPA_LO, 16'h1234);
    // Normal mode wrap and overflow
    wr(OFS_MASK, 8'h21);
    w16(OFS_CNT_LO, 16'hfffe);
    idle(5);
    r16(OFS_CNT_LO, 16'hfffe);
    tick(1);
    check(16'(overflow_irq), 16'h0000);
    tick(1);
    r16(OFS_CNT_LO, 16'h0000);
    tick(3);
    check(16'(overflow_irq), 16'h0001);
    pulse(overflow_irq_ack);
    check(16'(overflow_irq), 16'h0000);
    // Capture on pin, plain then filtered
    wr(OFS_CTRL2, 8'h40);
    w16(OFS_CNT_LO, 16'h0100);
    capture_pin = 1'b1;
    edge_wait(n0);
    r16(OFS_CAP_LO, 16'h0100);
    pulse(capture_irq_ack);
    check(16'(capture_irq), 16'h0000);
    capture_pin = 1'b0;
    idle(10);
    check(16'(capture_irq), 16'h0000);
    wr(OFS_CTRL2, 8'hc0);
    w16(OFS_CNT_LO, 16'h0200);
    capture_pin = 1'b1;
    idle(3);
    capture_pin = 1'b0;
    idle(12);
    check(16'(capture_irq), 16'h0000);
    capture_pin = 1'b1;
    edge_wait(n1);
    check(16'(n1 - n0), 16'h0004);
    r16(OFS_CAP_LO, 16'h0200);
    wr(OFS_FLAGS, 8'h20);
    check(16'(capture_irq), 16'h0000);
    // Comparator as capture source
    wr(OFS_CTRL2, 8'h40);
    capture_pin = 1'b0;
    comparator_capture_select = 1'b1;
    idle(8);
    wr(OFS_FLAGS, 8'h20);
    capture_pin = 1'b1;
    idle(10);
    check(16'(capture_irq), 16'h0000);
    comparator_output = 1'b1;
    edge_wait(n1);
    check(16'(n1), 16'(n0));
    comparator_capture_select = 1'b0;
    idle(8);
    wr(OFS_FLAGS, 8'h20);
    capture_pin = 1'b0;
    // Capture register as top in mode 12
    w16(OFS_CAP_LO, 16'h0005);
    r16(OFS_CAP_LO, 16'h0200);
    wr(OFS_CTRL2, 8'h58);
    w16(OFS_CAP_LO, 16'h0005);
    w16(OFS_CNT_LO, 16'h0000);
    capture_pin = 1'b1;
    tick(6);
    r16(OFS_CNT_LO, 16'h0000);
    check(16'(capture_irq), 16'h0000);
    r16(OFS_CAP_LO, 16'h0005);
    // Mode 4, every output action, forced and on match
    wr(OFS_CTRL2, 8'h08);
    w16(OFS_CMPA_LO, 16'h0003);
    w16(OFS_CMPB_LO, 16'h0001);
    w16(OFS_CNT_LO, 16'h0000);
    ea = 1'b0;
    eb = 1'b0;
    for (int i = 0; i < 4; i++) begin
      act = 2'(i + 1);
      wr(OFS_CTRL1, {act, act, 4'h0});
      check(16'({wave_ovr_a, wave_ovr_b}), 16'(act != 2'h0 ? 2'h3 : 2'h0));
      wr(OFS_FORCE, 8'hc0);
      idle(2);
      ea = nxt(ea, act);
      eb = nxt(eb, act);
      check(16'({wave_out_a, wave_out_b}), 16'({ea, eb}));
      tick(4);
      ea = nxt(ea, act);
      eb = nxt(eb, act);
      check(16'({wave_out_a, wave_out_b}), 16'({ea, eb}));
      r16(OFS_CNT_LO, 16'h0000);
    end
    // Fast PWM with capture register as top
    wr(OFS_CTRL2, 8'h18);
    wr(OFS_CTRL1, 8'hb2);
    w16(OFS_CAP_LO, 16'h0007);
    w16(OFS_CMPA_LO, 16'h0002);
    w16(OFS_CMPB_LO, 16'h0002);
    w16(OFS_CNT_LO, 16'h0000);
    tick(9);
    check(16'({wave_out_a, wave_out_b}), 16'h0002);
    tick(2);
    check(16'({wave_out_a, wave_out_b}), 16'h0001);
    w16(OFS_CMPA_LO, 16'h0007);
    tick(5);
    check(16'(wave_out_a), 16'h0001);
    wr(OFS_CTRL1, 8'h52);
    check(16'({wave_ovr_a, wave_ovr_b}), 16'h0002);
    tick(8);
    check(16'(wave_out_a), 16'h0000);
    wr(OFS_CTRL2, 8'h08);
    wr(OFS_CTRL1, 8'h51);
    check(16'({wave_ovr_a, wave_ovr_b}), 16'h0000);
    results();
  end
endmodule

// file: testbench/tmr_cpu_model.sv
`timescale 1ns/1ps
module tmr_cpu_model (
  input  wire logic         clock,
  output tmr_pkg::tmr_bus_s bus_req,
  input  wire logic [7:0]   bus_rdata
);
  import tmr_pkg::*;
  // Released bus shows inverted last values so stale requests never look valid
  initial bus_req = '{6'h3f, 8'hff, 1'b0, 1'b0};
  task automatic access(input logic [5:0] a, input logic [7:0] d, input logic w,
                        output logic [7:0] q);
    @(posedge clock);
    #1 bus_req = '{a, d, w, !w};
    @(posedge clock);
    #1 q = bus_rdata;
    bus_req = '{~a, ~d, 1'b0, 1'b0};
  endtask
  task automatic write16(input logic [5:0] lo, input logic [15:0] v);
    logic [7:0] q;
    access(lo + 6'h1, v[15:8], 1'b1, q);
    access(lo, v[7:0], 1'b1, q);
  endtask
  task automatic read16(input logic [5:0] lo, output logic [15:0] v);
    access(lo, 8'h00, 1'b0, v[7:0]);
    access(lo + 6'h1, 8'h00, 1'b0, v[15:8]);
  endtask
endmodule

// file: verilog/tmr_pkg.sv
package tmr_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFS_FLAGS     = 6'h20;
  localparam logic [5:0] OFS_MASK      = 6'h21;
  localparam logic [5:0] OFS_FORCE     = 6'h22;
  localparam logic [5:0] OFS_CAP_LO    = 6'h24;
  localparam logic [5:0] OFS_CAP_HI    = 6'h25;
  localparam logic [5:0] OFS_CMPB_LO   = 6'h28;
  localparam logic [5:0] OFS_CMPB_HI   = 6'h29;
  localparam logic [5:0] OFS_CMPA_LO   = 6'h2a;
  localparam logic [5:0] OFS_CMPA_HI   = 6'h2b;
  localparam logic [5:0] OFS_CNT_LO    = 6'h2c;
  localparam logic [5:0] OFS_CNT_HI    = 6'h2d;
  localparam logic [5:0] OFS_CTRL2     = 6'h2e;
  localparam logic [5:0] OFS_CTRL1     = 6'h2f;
  localparam logic [7:0] CTRL1_RST     = 8'h00;
  localparam logic [7:0] CTRL1_RMASK   = 8'hf3;
  localparam logic [7:0] CTRL2_RMASK   = 8'hd8;
  localparam int unsigned BIT_ACT_A    = 6;
  localparam int unsigned BIT_ACT_B    = 4;
  localparam int unsigned BIT_NC_EN    = 7;
  localparam int unsigned BIT_EDGE     = 6;
  localparam int unsigned BIT_WGM_HI   = 3;
  localparam int unsigned BIT_CAP_FLAG = 5;
  localparam int unsigned BIT_OVF_FLAG = 0;
  localparam int unsigned BIT_FORCE_A  = 7;
  localparam int unsigned BIT_FORCE_B  = 6;
  localparam int unsigned NC_DEPTH     = 4;
  localparam logic [3:0] WGM_NORMAL    = 4'h0;
  localparam logic [3:0] WGM_CTC_A     = 4'h4;
  localparam logic [3:0] WGM_FAST_8    = 4'h5;
  localparam logic [3:0] WGM_FAST_9    = 4'h6;
  localparam logic [3:0] WGM_FAST_10   = 4'h7;
  localparam logic [3:0] WGM_CTC_CAP   = 4'hc;
  localparam logic [3:0] WGM_FAST_CAP  = 4'he;
  localparam logic [3:0] WGM_FAST_A    = 4'hf;
  localparam logic [15:0] TOP_8        = 16'h00ff;
  localparam logic [15:0] TOP_9        = 16'h01ff;
  localparam logic [15:0] TOP_10       = 16'h03ff;
  localparam logic [15:0] TOP_MAX      = 16'hffff;
  localparam logic [1:0] ACT_OFF       = 2'h0;
  localparam logic [1:0] ACT_TOGGLE    = 2'h1;
  localparam logic [1:0] ACT_LOW       = 2'h2;
  localparam logic [1:0] ACT_HIGH      = 2'h3;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr_bus_s;
endpackage

// file: verilog/tmr_timer16.sv
`timescale 1ns/1ps
module tmr_timer16
(
  input  wire logic           clock,
  input  wire logic           nrst,
  input  tmr_pkg::tmr_bus_s   bus_req,
  output logic [7:0]          bus_rdata,
  input  wire logic           timer_tick,
  input  wire logic           capture_pin,
  input  wire logic           comparator_output,
  input  wire logic           comparator_capture_select,
  input  wire logic           capture_irq_ack,
  input  wire logic           overflow_irq_ack,
  output logic                capture_irq,
  output logic                overflow_irq,
  output logic                wave_out_a,
  output logic                wave_out_b,
  output logic                wave_ovr_a,
  output logic                wave_ovr_b
);
  import tmr_pkg::*;

  logic [1:0]  sync_pin_reg, sync_cmp_reg;
  logic [NC_DEPTH-1:0] nc_reg, nc_next;
  logic        filt_reg, filt_next, prev_reg, prev_next;
  logic [7:0]  ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next, temp_reg, temp_next;
  logic [15:0] cnt_reg, cnt_next, cmpa_reg, cmpa_next, cmpb_reg, cmpb_next;
  logic [15:0] cap_reg, cap_next;
  logic        capf_reg, capf_next, ovf_reg, ovf_next, capie_reg, capie_next;
  logic        ovie_reg, ovie_next;
  logic [1:0]  wave_reg, wave_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [3:0]  wgm;
  logic [15:0] top;
  logic        fast_pwm, non_pwm, cap_is_top, clr_at_top, src, sample, cap_edge;
  logic        at_top, wr_lo, wr;
  logic [1:0]  act [2];
  logic [1:0]  match, force_ch;
  logic [15:0] cmp [2];

  // Two-stage synchronizers on both capture sources
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_pin_reg <= 2'h0;
      sync_cmp_reg <= 2'h0;
    end else begin
      sync_pin_reg <= {sync_pin_reg[0], capture_pin};
      sync_cmp_reg <= {sync_cmp_reg[0], comparator_output};
    end
  end

  always_comb begin
    wgm        = {ctrl2_reg[BIT_WGM_HI+1:BIT_WGM_HI], ctrl1_reg[1:0]};
    fast_pwm   = (wgm == WGM_FAST_8) || (wgm == WGM_FAST_9) || (wgm == WGM_FAST_10) ||
                 (wgm == WGM_FAST_CAP) || (wgm == WGM_FAST_A);
    non_pwm    = (wgm == WGM_NORMAL) || (wgm == WGM_CTC_A) || (wgm == WGM_CTC_CAP);
    cap_is_top = (wgm == WGM_CTC_CAP) || (wgm == WGM_FAST_CAP);
    clr_at_top = fast_pwm || (wgm == WGM_CTC_A) || (wgm == WGM_CTC_CAP);
    case (wgm)
      WGM_CTC_A, WGM_FAST_A:     top = cmpa_reg;
      WGM_CTC_CAP, WGM_FAST_CAP: top = cap_reg;
      WGM_FAST_8:                top = TOP_8;
      WGM_FAST_9:                top = TOP_9;
      WGM_FAST_10:               top = TOP_10;
      default:                   top = TOP_MAX;
    endcase
    at_top   = clr_at_top ? (cnt_reg == top) : (cnt_reg == TOP_MAX);
    src      = comparator_capture_select ? sync_cmp_reg[1] : sync_pin_reg[1];
    sample   = src;
    act[0]   = ctrl1_reg[BIT_ACT_A+1:BIT_ACT_A];
    act[1]   = ctrl1_reg[BIT_ACT_B+1:BIT_ACT_B];
    cmp[0]   = cmpa_reg;
    cmp[1]   = cmpb_reg;
    wr       = bus_req.wr;
    force_ch = {bus_req.wdata[BIT_FORCE_B], bus_req.wdata[BIT_FORCE_A]} &
               {2{wr && (bus_req.addr == OFS_FORCE) && non_pwm}};
  end

  // Per-channel compare match on counting cycles
  for (genvar ch = 0; ch < 2; ch++) begin : g_match
    assign match[ch] = timer_tick && (cnt_reg == cmp[ch]);
  end

  always_comb begin
    nc_next    = {nc_reg[NC_DEPTH-2:0], sample};
    filt_next  = filt_reg;
    if (!ctrl2_reg[BIT_NC_EN]) begin
      filt_next = sample;
    end else if (&nc_reg) begin
      filt_next = 1'b1;
    end else if (~|nc_reg) begin
      filt_next = 1'b0;
    end
    prev_next  = filt_reg;
    cap_edge   = !cap_is_top && (ctrl2_reg[BIT_EDGE] ? (filt_reg && !prev_reg)
                                                     : (!filt_reg && prev_reg));
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    temp_next  = temp_reg;
    cnt_next   = cnt_reg;
    cmpa_next  = cmpa_reg;
    cmpb_next  = cmpb_reg;
    cap_next   = cap_reg;
    capie_next = capie_reg;
    ovie_next  = ovie_reg;
    capf_next  = capf_reg;
    ovf_next   = ovf_reg;
    rdata_next = rdata_reg;
    wave_next  = wave_reg;
    wr_lo      = 1'b0;

    if (timer_tick) begin
      cnt_next = at_top ? 16'h0000 : cnt_reg + 16'h0001;
    end

    if (capture_irq_ack || (wr && bus_req.addr == OFS_FLAGS && bus_req.wdata[BIT_CAP_FLAG])) begin
      capf_next = 1'b0;
    end
    if (overflow_irq_ack || (wr && bus_req.addr == OFS_FLAGS && bus_req.wdata[BIT_OVF_FLAG])) begin
      ovf_next = 1'b0;
    end

    if (wr) begin
      case (bus_req.addr)
        OFS_CTRL1:   ctrl1_next = bus_req.wdata & CTRL1_RMASK;
        OFS_CTRL2:   ctrl2_next = bus_req.wdata & CTRL2_RMASK;
        OFS_MASK: begin
          capie_next = bus_req.wdata[BIT_CAP_FLAG];
          ovie_next  = bus_req.wdata[BIT_OVF_FLAG];
        end
        OFS_CNT_HI, OFS_CMPA_HI, OFS_CMPB_HI, OFS_CAP_HI: temp_next = bus_req.wdata;
        OFS_CNT_LO: begin
          cnt_next = {temp_reg, bus_req.wdata};
          wr_lo    = 1'b1;
        end
        OFS_CMPA_LO: cmpa_next = {temp_reg, bus_req.wdata};
        OFS_CMPB_LO: cmpb_next = {temp_reg, bus_req.wdata};
        OFS_CAP_LO: begin
          if (cap_is_top) begin
            cap_next = {temp_reg, bus_req.wdata};
          end
        end
        default: ;
      endcase
    end

    // Set beats clear in the same cycle
    if (timer_tick && at_top && !wr_lo && ((wgm == WGM_NORMAL) || fast_pwm)) begin
      ovf_next = 1'b1;
    end
    if (cap_edge) begin
      cap_next  = cnt_reg;
      capf_next = 1'b1;
    end

    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_CTRL1:   rdata_next = ctrl1_reg;
        OFS_CTRL2:   rdata_next = ctrl2_reg;
        OFS_FLAGS:   rdata_next = {2'h0, capf_reg, 4'h0, ovf_reg};
        OFS_MASK:    rdata_next = {2'h0, capie_reg, 4'h0, ovie_reg};
        OFS_CNT_LO: begin
          rdata_next = cnt_reg[7:0];
          temp_next  = cnt_reg[15:8];
        end
        OFS_CAP_LO: begin
          rdata_next = cap_reg[7:0];
          temp_next  = cap_reg[15:8];
        end
        OFS_CNT_HI, OFS_CAP_HI: rdata_next = temp_reg;
        OFS_CMPA_LO: rdata_next = cmpa_reg[7:0];
        OFS_CMPA_HI: rdata_next = cmpa_reg[15:8];
        OFS_CMPB_LO: rdata_next = cmpb_reg[7:0];
        OFS_CMPB_HI: rdata_next = cmpb_reg[15:8];
        default:     rdata_next = 8'h00;
      endcase
    end

    for (int ch = 0; ch < 2; ch++) begin
      if (non_pwm && (match[ch] || force_ch[ch])) begin
        case (act[ch])
          ACT_TOGGLE: wave_next[ch] = !wave_reg[ch];
          ACT_LOW:    wave_next[ch] = 1'b0;
          ACT_HIGH:   wave_next[ch] = 1'b1;
          default:    wave_next[ch] = wave_reg[ch];
        endcase
      end else if (fast_pwm) begin
        if (timer_tick && at_top && act[ch][1]) begin
          wave_next[ch] = (act[ch] == ACT_LOW);
        end else if (match[ch] && act[ch][1] && (cmp[ch] != top)) begin
          wave_next[ch] = (act[ch] == ACT_HIGH);
        end else if (match[ch] && ch == 0 && act[ch] == ACT_TOGGLE && wgm[3]) begin
          wave_next[ch] = !wave_reg[ch];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nc_reg    <= '0;
      filt_reg  <= 1'b0;
      prev_reg  <= 1'b0;
      ctrl1_reg <= CTRL1_RST;
      ctrl2_reg <= 8'h00;
      temp_reg  <= 8'h00;
      cnt_reg   <= 16'h0000;
      cmpa_reg  <= 16'h0000;
      cmpb_reg  <= 16'h0000;
      cap_reg   <= 16'h0000;
      capie_reg <= 1'b0;
      ovie_reg  <= 1'b0;
      capf_reg  <= 1'b0;
      ovf_reg   <= 1'b0;
      rdata_reg <= 8'h00;
      wave_reg  <= 2'h0;
    end else begin
      nc_reg    <= nc_next;
      filt_reg  <= filt_next;
      prev_reg  <= prev_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      temp_reg  <= temp_next;
      cnt_reg   <= cnt_next;
      cmpa_reg  <= cmpa_next;
      cmpb_reg  <= cmpb_next;
      cap_reg   <= cap_next;
      capie_reg <= capie_next;
      ovie_reg  <= ovie_next;
      capf_reg  <= capf_next;
      ovf_reg   <= ovf_next;
      rdata_reg <= rdata_next;
      wave_reg  <= wave_next;
    end
  end

  always_comb begin
    bus_rdata    = rdata_reg;
    capture_irq  = capf_reg && capie_reg;
    overflow_irq = ovf_reg && ovie_reg;
    wave_out_a   = wave_reg[0];
    wave_out_b   = wave_reg[1];
    wave_ovr_a   = (act[0] != ACT_OFF) &&
                   !(fast_pwm && act[0] == ACT_TOGGLE && !wgm[3]);
    wave_ovr_b   = (act[1] != ACT_OFF) && !(fast_pwm && act[1] == ACT_TOGGLE);
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_lo_write_joins: assert property (wr && bus_req.addr == OFS_CMPA_LO |=>
    cmpa_reg == {$past(temp_reg), $past(bus_req.wdata)})
    else $error("compare A low write did not load held high byte");
  a_cmp_hi_direct: assert property (bus_req.rd && bus_req.addr == OFS_CMPB_HI |=>
    bus_rdata == $past(cmpb_reg[15:8]))
    else $error("compare B high read not direct");
  a_cap_lo_temp: assert property (bus_req.rd && bus_req.addr == OFS_CAP_LO && !wr |=>
    temp_reg == $past(cap_reg[15:8]))
    else $error("capture low read did not load holding register");
  a_capture_copy: assert property (cap_edge |=> cap_reg == $past(cnt_reg) && capf_reg)
    else $error("capture did not copy counter and set flag");
  a_cap_ack_clear: assert property (capture_irq_ack && !cap_edge |=> !capf_reg)
    else $error("capture flag not cleared by interrupt acknowledge");
  a_cap_wr_guard: assert property (!cap_is_top && !cap_edge |=> $stable(cap_reg))
    else $error("capture register changed without capture");
  a_cap_top_quiet: assert property (cap_is_top && !(wr && bus_req.addr == OFS_CAP_LO) |=>
    $stable(cap_reg))
    else $error("capture front end active in capture-top mode");
  a_normal_wrap: assert property (wgm == WGM_NORMAL && timer_tick && cnt_reg == TOP_MAX &&
    !wr |=> cnt_reg == 16'h0000 && ovf_reg)
    else $error("normal mode wrap or overflow flag wrong");
  a_ctc_clear: assert property (wgm == WGM_CTC_A && timer_tick && cnt_reg == cmpa_reg &&
    !wr |=> cnt_reg == 16'h0000)
    else $error("clear on match A failed");
  a_no_tick_hold: assert property (!timer_tick && !wr |=> $stable(cnt_reg))
    else $error("counter moved without tick");
  a_action_zero: assert property (act[0] == ACT_OFF && !fast_pwm |=> $stable(wave_out_a))
    else $error("action zero changed output A");
  a_np_toggle: assert property (non_pwm && act[1] == ACT_TOGGLE && match[1] |=>
    wave_out_b != $past(wave_out_b))
    else $error("toggle on match B missing");
  a_fast_bottom: assert property (fast_pwm && act[0] == ACT_LOW && timer_tick && at_top |=>
    wave_out_a)
    else $error("non-inverting set at bottom missing");

  c_capture: cover property (cap_edge ##1 capture_irq);
  c_ctc_wrap: cover property (wgm == WGM_CTC_A && timer_tick && at_top);
  c_fast_pwm: cover property (fast_pwm && match[0] ##[1:20] fast_pwm && at_top && timer_tick);
  c_force: cover property (|force_ch);
endmodule
